// ===== bench/mad_adc_props.sv
// Port checker of the converter control block.
// Assumes bind onto mad_adc_ctrl, one clock domain.
`default_nettype none
module mad_adc_props
   import mad_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic ARST_N_IN,
   input wire mad_axil_req_type AXI_IN,
   input wire mad_axil_rsp_type AXI_OUT,
   input wire logic [1:0] MODE_SELECT_IN,
   input wire logic MOD_CLK_OUT,
   input wire logic [NUM_CH-1:0] CHAN_ON_OUT,
   input wire logic INT_REF_BUF_EN_OUT,
   input wire logic OUTSIDE_REFERENCE_SELECT_SEL_OUT,
   input wire logic READY_PIN_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   logic [15:0] hi_cnt;
   logic [15:0] gap;
   logic seen;
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         hi_cnt <= 16'h0000;
         gap <= 16'h0000;
         seen <= 1'b0;
      end else begin
         hi_cnt <= READY_PIN_OUT ? hi_cnt + 16'h0001 : 16'h0000;
         gap <= $rose(READY_PIN_OUT) ? 16'h0000 : gap + 16'h0001;
         seen <= seen | $rose(READY_PIN_OUT);
      end
   end
   a_modulator_sample_clock_high: assert property ($rose(MOD_CLK_OUT) |-> MOD_CLK_OUT[*6] ##1 !MOD_CLK_OUT)
      else $error("modulator clock high phase wrong");
   a_modulator_sample_clock_low: assert property ($fell(MOD_CLK_OUT) |-> (!MOD_CLK_OUT)[*6] ##1 MOD_CLK_OUT)
      else $error("modulator clock low phase wrong");
   a_pin_width: assert property ($fell(READY_PIN_OUT) |-> hi_cnt == 16'h000C)
      else $error("ready pulse width wrong");
   a_pulse_gap: assert property ($rose(READY_PIN_OUT) && seen |-> gap == 16'h0BFF)
      else $error("ready pulse spacing wrong");
   a_ref_select: assert property (OUTSIDE_REFERENCE_SELECT_SEL_OUT != INT_REF_BUF_EN_OUT)
      else $error("reference buffer and select agree");
   a_idle_off: assert property ((&MODE_SELECT_IN)[*5] |-> CHAN_ON_OUT == '0)
      else $error("channel on in idle mode");
   a_read_resp: assert property (AXI_IN.arvalid && AXI_OUT.arready |=> AXI_OUT.rvalid)
      else $error("read answer late");
   a_write_resp: assert property (AXI_IN.awvalid && AXI_OUT.awready && AXI_IN.wvalid && AXI_OUT.wready
      |-> ##2 AXI_OUT.bvalid)
      else $error("write answer late");
endmodule
bind mad_adc_ctrl mad_adc_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .ARST_N_IN(ARST_N_IN), .AXI_IN(AXI_IN),
   .AXI_OUT(AXI_OUT), .MODE_SELECT_IN(MODE_SELECT_IN), .MOD_CLK_OUT(MOD_CLK_OUT), .CHAN_ON_OUT(CHAN_ON_OUT),
   .INT_REF_BUF_EN_OUT(INT_REF_BUF_EN_OUT), .OUTSIDE_REFERENCE_SELECT_SEL_OUT(OUTSIDE_REFERENCE_SELECT_SEL_OUT), .READY_PIN_OUT(READY_PIN_OUT));
`default_nettype wire

// ===== bench/mad_mod_model.sv
// Far-side model: seven modulator bit streams.
// Assumes modulator clock and channel power come from the block.
`default_nettype none
module mad_mod_model
   import mad_pkg::*;
(
   input wire logic mclk_in,
   input wire logic [NUM_CH-1:0] chan_on_in,
   output logic [NUM_CH-1:0] bits_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ph;
   initial begin
      ph = 1'b0;
      bits_out = '0;
   end
   // Unpowered streams toggle, so a stale level never passes as data
   always @(posedge mclk_in) begin
      ph <= ~ph;
      for (int k = 0; k < NUM_CH; k++) begin
         bits_out[k] <= !chan_on_in[k] ? ph : (k % 3 == 0) ? 1'b1 : (k % 3 == 1) ? 1'b0 : ph;
      end
   end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the converter control block.
// Assumes the modulator model on the far side; this bench is bus master.
`default_nettype none
module testbench
   import mad_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, mclk, pin, irq, int_ref, outside_reference_select;
   mad_axil_req_type req;
   mad_axil_rsp_type rsp;
   logic [6:0] mbits, chan_on;
   logic [1:0] mode;
   logic [13:0] gain;
   int bad_count, num_checks;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   mad_adc_ctrl u_dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .AXI_IN(req), .AXI_OUT(rsp), .MOD_BITS_IN(mbits),
      .MODE_SELECT_IN(mode), .MOD_CLK_OUT(mclk), .CHAN_ON_OUT(chan_on), .GAIN_OUT(gain),
      .INT_REF_BUF_EN_OUT(int_ref), .OUTSIDE_REFERENCE_SELECT_SEL_OUT(outside_reference_select), .READY_PIN_OUT(pin), .IRQ_OUT(irq));
   mad_mod_model u_mod (.mclk_in(mclk), .chan_on_in(chan_on), .bits_out(mbits));
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      do begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      do begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, d, e);
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      chk("int ref", 32'(int_ref), 32'h00000001);
      // Time the modulator clock from one rise to the next
      while (mclk !== 1'b0) @(posedge clk);
      while (mclk !== 1'b1) @(posedge clk);
      n = 0;
      while (mclk === 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("modulator_sample_clock high", 32'(n), 32'h00000006);
      while (mclk !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("modulator_sample_clock period", 32'(n), 32'h0000000C);
      rdc("status", FIRST_STATUS_OFS, 32'h00000000);
      rdc("fs sinc", FS_SINC_OFS, 32'h03FFFBCA);
      rdc("fs lpf", FS_LPF_OFS, 32'h0471108C);
      rd(8'h80, d, r);
      chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
      chk("unmapped data", d, 32'h00000000);
   endtask
   task automatic t_cfg();
      wr(GENERAL_CONFIG_OFS, 32'h00000001);
      rdc("config", GENERAL_CONFIG_OFS, 32'h00000001);
      chk("outside_reference_select", 32'(outside_reference_select), 32'h00000001);
      chk("int ref off", 32'(int_ref), 32'h00000000);
      wr(AMP_GAIN_OFS, 32'h00000624);
      wr(SHUTDOWN_OFS, 32'h00000010);
      rdc("gain reg", AMP_GAIN_OFS, 32'h00000624);
      chk("gain pins", 32'(gain), 32'h00000624);
      chk("chan on", 32'(chan_on), 32'h0000006F);
   endtask
   task automatic t_data();
      logic [31:0] e;
      wr(STATUS_CLEAR_OFS, 32'h00000003);
      wr(IRQ_ENABLE_OFS, 32'h00000001);
      while (irq !== 1'b1) @(posedge clk);
      rdc("status set", FIRST_STATUS_OFS, 32'h00000003);
      wr(STATUS_CLEAR_OFS, 32'h00000001);
      rdc("status clear", FIRST_STATUS_OFS, 32'h00000002);
      chk("irq cleared", 32'(irq), 32'h00000000);
      // First set holds partial windows; judge the second
      while (irq !== 1'b1) @(posedge clk);
      for (int k = 0; k < NUM_CH; k++) begin
         e = (k == 4 || k % 3 == 2) ? 32'h00000000 : (k % 3 == 0) ? 32'h04000000 : 32'hFC000000;
         rdc("lpf word", WAVE_LPF_BASE + 8'(4 * k), e);
         rdc("sinc word", WAVE_SINC_BASE + 8'(4 * k), e);
      end
   endtask
   task automatic t_pulse();
      int n;
      wr(GENERAL_CONFIG_OFS, 32'h000000C0);
      while (pin !== 1'b1) @(posedge clk);
      n = 0;
      while (pin === 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("pin width", 32'(n), 32'h0000000C);
      while (pin !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      chk("pin spacing", 32'(n), 32'h00000C00);
      wr(IRQ_ENABLE_OFS, 32'h00000000);
      rdc("status held", FIRST_STATUS_OFS, 32'h00000003);
      chk("irq masked", 32'(irq), 32'h00000000);
      // Pulse runs out before the pin function is turned off
      while (pin === 1'b1) @(posedge clk);
      wr(GENERAL_CONFIG_OFS, 32'h00000000);
   endtask
   task automatic t_idle();
      mode <= 2'b11;
      repeat (6) @(posedge clk);
      chk("idle off", 32'(chan_on), 32'h00000000);
      wr(SHUTDOWN_OFS, 32'h00000000);
      rdc("power state", POWER_STATE_OFS, 32'h00000001);
      chk("still off", 32'(chan_on), 32'h00000000);
      mode <= 2'b00;
      repeat (6) @(posedge clk);
      chk("normal on", 32'(chan_on), 32'h0000007F);
   endtask
   // About four sample sets of traffic; about thirteen sets before giving up
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   initial begin
      bad_count = 0;
      num_checks = 0;
      rst_n = 1'b0;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      req.wstrb = 4'hF;
      mode = 2'b01;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_data();
      t_pulse();
      t_idle();
      summarize();
   end
endmodule
`default_nettype wire

// ===== logic/mad_adc_ctrl.sv
// Converter control: modulator clock, sinc and low-pass decimation, result store, AXI4-Lite registers.
// Assumes one-bit modulator streams and mode pins arriving asynchronously from outside.
`default_nettype none
module mad_adc_ctrl
   import mad_pkg::*;
(
   input wire logic CORE_CLK_IN,
   input wire logic ARST_N_IN,
   input wire mad_axil_req_type AXI_IN,
   output mad_axil_rsp_type AXI_OUT,
   input wire logic [NUM_CH-1:0] MOD_BITS_IN,
   input wire logic [1:0] MODE_SELECT_IN,
   output logic MOD_CLK_OUT,
   output logic [NUM_CH-1:0] CHAN_ON_OUT,
   output logic [2*NUM_CH-1:0] GAIN_OUT,
   output logic INT_REF_BUF_EN_OUT,
   output logic OUTSIDE_REFERENCE_SELECT_SEL_OUT,
   output logic READY_PIN_OUT,
   output logic IRQ_OUT
);
   mad_state_type s;
   mad_state_type n;
   logic idle;
   logic tick;
   logic sinc_done;
   logic lpf_done;
   logic [6:0] cnt_now;
   logic [ADC_W-1:0] sinc_val;
   logic [25:0] lpf_sum;
   logic [1:0] clr;
   logic [1:0] set;
   logic [31:0] wtmp;

   function automatic logic [ADC_W-1:0] sinc_code(input logic [6:0] c);
      logic [24:0] t;
      t = {1'b0, c, 17'h0} - 25'h0400000;
      return t[ADC_W-1:0];
   endfunction

   function automatic logic [31:0] store_fmt(input logic [ADC_W-1:0] d);
      return {{4{d[ADC_W-1]}}, d, 4'h0};
   endfunction

   function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [33:0] read_reg(input mad_state_type q, input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      logic ok;
      d = 32'h0;
      ok = 1'b1;
      if (a[7:5] == WAVE_LPF_BASE[7:5] && a[4:2] != 3'h7) begin
         d = store_fmt(q.lpf_res[a[4:2]]);
      end else if (a[7:5] == WAVE_SINC_BASE[7:5] && a[4:2] != 3'h7) begin
         d = store_fmt(q.sinc_res[a[4:2]]);
      end else begin
         unique case (a)
            GENERAL_CONFIG_OFS: d = q.cfg;
            AMP_GAIN_OFS: d = {18'h0, q.gain};
            SHUTDOWN_OFS: d = {25'h0, q.shutdown};
            FIRST_STATUS_OFS: d = {30'h0, q.status};
            IRQ_ENABLE_OFS: d = {30'h0, q.irq_en};
            POWER_STATE_OFS: d = {31'h0, &q.pm_s2};
            FS_SINC_OFS: d = FS_SINC_CODE;
            FS_LPF_OFS: d = FS_LPF_CODE;
            STATUS_CLEAR_OFS: d = 32'h0;
            default: ok = 1'b0;
         endcase
      end
      if (a[1:0] != 2'h0) begin
         ok = 1'b0;
      end
      return {ok ? RESP_OKAY : RESP_SLVERR, ok ? d : 32'h0};
   endfunction

   always_comb begin
      n = s;
      idle = 1'b0;
      tick = 1'b0;
      sinc_done = 1'b0;
      lpf_done = 1'b0;
      cnt_now = 7'h0;
      sinc_val = '0;
      lpf_sum = '0;
      clr = 2'h0;
      set = 2'h0;
      wtmp = '0;

      // Pins from outside pass two flops before use
      n.pm_s1 = MODE_SELECT_IN;
      n.pm_s2 = s.pm_s1;
      n.mb_s1 = MOD_BITS_IN;
      n.mb_s2 = s.mb_s1;
      idle = &s.pm_s2;

      // Divider runs even in idle so the modulators see a steady clock on wake
      tick = (s.div == DIV_LAST);
      n.div = tick ? 4'h0 : s.div + 4'h1;
      // Low half first, so the reset value already sits in phase
      n.mclk = (n.div >= DIV_HALF);

      // Idle wins over any shutdown or enable setting
      n.chan_on = idle ? '0 : ~s.shutdown;

      if (idle) begin
         n.sinc_cnt = 6'h0;
         n.lpf_phase = 2'h0;
         n.ones = '0;
         n.lpf_acc = '0;
      end else if (tick) begin
         sinc_done = (s.sinc_cnt == SINC_LAST);
         lpf_done = sinc_done && (s.lpf_phase == LPF_LAST);
         n.sinc_cnt = s.sinc_cnt + 6'h1;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            // All channels advance on the same tick: simultaneous sampling
            cnt_now = s.ones[ch] + {6'h0, s.mb_s2[ch] & s.chan_on[ch]};
            n.ones[ch] = sinc_done ? 7'h0 : cnt_now;
            if (sinc_done) begin
               // Disabled channels store zero rather than a full negative code
               sinc_val = s.chan_on[ch] ? sinc_code(cnt_now) : '0;
               n.sinc_res[ch] = sinc_val;
               lpf_sum = s.lpf_acc[ch] + {{2{sinc_val[ADC_W-1]}}, sinc_val};
               n.lpf_acc[ch] = lpf_done ? 26'h0 : lpf_sum;
               if (lpf_done) begin
                  n.lpf_res[ch] = lpf_sum[25:2];
               end
            end
         end
         if (sinc_done) begin
            n.lpf_phase = s.lpf_phase + 2'h1;
         end
      end

      set[STAT_READY_BIT] = lpf_done;
      set[STAT_SINC_BIT] = sinc_done;

      // Ready pin: one modulator period, only with the ready function selected
      if (lpf_done && s.cfg[CFG_PULSE_LSB+2 +: 2] == PULSE_READY_SEL) begin
         n.pulse = 1'b1;
         n.pulse_cnt = DIV_LAST;
      end else if (s.pulse_cnt != 4'h0) begin
         n.pulse_cnt = s.pulse_cnt - 4'h1;
      end else begin
         n.pulse = 1'b0;
      end

      // AXI4-Lite write: address and data taken in either order
      if (AXI_IN.awvalid && !s.aw_got && !s.bvalid) begin
         n.aw_got = 1'b1;
         n.waddr = AXI_IN.awaddr;
      end
      if (AXI_IN.wvalid && !s.w_got && !s.bvalid) begin
         n.w_got = 1'b1;
         n.wdata = AXI_IN.wdata;
         n.wstrb = AXI_IN.wstrb;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         if (s.waddr[1:0] != 2'h0) begin
            n.bresp = RESP_SLVERR;
         end else begin
            unique case (s.waddr)
               GENERAL_CONFIG_OFS: n.cfg = strobe(s.cfg, s.wdata, s.wstrb);
               AMP_GAIN_OFS: begin
                  wtmp = strobe({18'h0, s.gain}, s.wdata, s.wstrb);
                  n.gain = wtmp[2*NUM_CH-1:0];
               end
               SHUTDOWN_OFS: begin
                  wtmp = strobe({25'h0, s.shutdown}, s.wdata, s.wstrb);
                  n.shutdown = wtmp[NUM_CH-1:0];
               end
               STATUS_CLEAR_OFS: clr = s.wstrb[0] ? s.wdata[1:0] : 2'h0;
               IRQ_ENABLE_OFS: begin
                  wtmp = strobe({30'h0, s.irq_en}, s.wdata, s.wstrb);
                  n.irq_en = wtmp[1:0];
               end
               // Read-only status, power state and full-scale words accept and ignore writes
               FIRST_STATUS_OFS, POWER_STATE_OFS, FS_SINC_OFS, FS_LPF_OFS: n.bresp = RESP_OKAY;
               default: n.bresp = RESP_SLVERR;
            endcase
         end
      end
      if (s.bvalid && AXI_IN.bready) begin
         n.bvalid = 1'b0;
      end

      // Set wins over a clear in the same cycle
      n.status = (s.status & ~clr) | set;

      if (AXI_IN.arvalid && !s.rvalid) begin
         {n.rresp, n.rdata} = read_reg(s, AXI_IN.araddr);
         n.rvalid = 1'b1;
      end
      if (s.rvalid && AXI_IN.rready) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         s <= MAD_STATE_RESET;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      AXI_OUT.awready = !s.aw_got && !s.bvalid;
      AXI_OUT.wready = !s.w_got && !s.bvalid;
      AXI_OUT.bvalid = s.bvalid;
      AXI_OUT.bresp = s.bresp;
      AXI_OUT.arready = !s.rvalid;
      AXI_OUT.rvalid = s.rvalid;
      AXI_OUT.rdata = s.rdata;
      AXI_OUT.rresp = s.rresp;
   end

   assign MOD_CLK_OUT = s.mclk;
   assign CHAN_ON_OUT = s.chan_on;
   assign GAIN_OUT = s.gain;
   assign OUTSIDE_REFERENCE_SELECT_SEL_OUT = s.cfg[CFG_EXTREF_BIT];
   assign INT_REF_BUF_EN_OUT = !s.cfg[CFG_EXTREF_BIT];
   assign READY_PIN_OUT = s.pulse;
   assign IRQ_OUT = |(s.status & s.irq_en);
endmodule
`default_nettype wire

// ===== logic/mad_pkg.sv
// Constants, register map and carrier types of the seven-channel converter control block.
// Assumes a single 200 MHz core clock that also serves as the converter input clock.
// Overview of operation
// - Seven channels sample on one shared modulator tick, each giving 24-bit signed results.
// - Per-channel two-bit gain field selects amplifier gain one, two or four.
// - Outside reference select turns internal reference buffer off, converting against external reference.
// - Enabled channels convert continuously; shutdown register switches individual channels off.
// - Normal power mode keeps channels on; idle mode forces all channels off.
// - Each completed conversion sets the sample set ready status bit.
// - Pulse function select bits 7:6 equal 11 make the shared pin pulse per sample set.
// - Modulator sample clock is the input clock divided by twelve.
// - Sinc stage emits one sample per sixty-four modulator periods.
// - Low-pass decimator divides sinc rate by four more.
// - Stored words: result in 27:4, sign in 31:28, zeros in 3:0.
// - Full-scale sinc-stage buffer code is decimal 67,107,786.
// - Full-scale decimator-stage buffer code is decimal 74,518,668.
`default_nettype none
package mad_pkg;
   localparam int CORE_CLK_HZ = 200_000_000;
   localparam int MOD_DIV = 12;
   localparam int MOD_CLK_HZ = CORE_CLK_HZ / MOD_DIV;
   localparam int SINC_DECIM = 64;
   localparam int LPF_DECIM = 4;
   localparam int NUM_CH = 7;
   localparam int ADC_W = 24;
   localparam int ADDR_W = 8;
   localparam logic [3:0] DIV_LAST = 4'(MOD_DIV - 1);
   localparam logic [3:0] DIV_HALF = 4'(MOD_DIV / 2);
   localparam logic [5:0] SINC_LAST = 6'(SINC_DECIM - 1);
   localparam logic [1:0] LPF_LAST = 2'(LPF_DECIM - 1);
   localparam logic [ADDR_W-1:0] GENERAL_CONFIG_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] AMP_GAIN_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] SHUTDOWN_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] FIRST_STATUS_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] STATUS_CLEAR_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] POWER_STATE_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] FS_SINC_OFS = 8'h1C;
   localparam logic [ADDR_W-1:0] WAVE_LPF_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] WAVE_SINC_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] FS_LPF_OFS = 8'h60;
   localparam int CFG_EXTREF_BIT = 0;
   localparam int CFG_PULSE_LSB = 4;
   localparam logic [1:0] PULSE_READY_SEL = 2'h3;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_SINC_BIT = 1;
   localparam logic [31:0] FS_SINC_CODE = 32'h03FFFBCA;
   localparam logic [31:0] FS_LPF_CODE = 32'h0471108C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } mad_axil_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mad_axil_rsp_type;

   typedef struct packed {
      logic [1:0] pm_s1;
      logic [1:0] pm_s2;
      logic [NUM_CH-1:0] mb_s1;
      logic [NUM_CH-1:0] mb_s2;
      logic [3:0] div;
      logic mclk;
      logic [5:0] sinc_cnt;
      logic [1:0] lpf_phase;
      logic [NUM_CH-1:0][6:0] ones;
      logic [NUM_CH-1:0][25:0] lpf_acc;
      logic [NUM_CH-1:0][ADC_W-1:0] sinc_res;
      logic [NUM_CH-1:0][ADC_W-1:0] lpf_res;
      logic [NUM_CH-1:0] chan_on;
      logic [31:0] cfg;
      logic [2*NUM_CH-1:0] gain;
      logic [NUM_CH-1:0] shutdown;
      logic [1:0] status;
      logic [1:0] irq_en;
      logic [3:0] pulse_cnt;
      logic pulse;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mad_state_type;

   localparam mad_state_type MAD_STATE_RESET = '0;
endpackage
`default_nettype wire
